// file: rtl/fse_pkg.sv
package fse_pkg;

   // ****************************************
   // storage geometry and frame layout
   // ****************************************
   localparam int unsigned NUM_BLOCKS   = 119;
   localparam int unsigned BLOCK_BYTES  = 512;
   localparam int unsigned BLK_W        = 7;
   localparam int unsigned OFS_W        = 9;
   localparam logic [2:0]  HB_CODE      = 3'h0;
   localparam logic [2:0]  HB_OPT       = 3'h1;
   localparam logic [2:0]  HB_BLK_HI    = 3'h2;
   localparam logic [2:0]  HB_BLK_LO    = 3'h3;
   localparam logic [2:0]  HB_OFS_HI    = 3'h4;
   localparam logic [2:0]  HB_OFS_LO    = 3'h5;
   localparam logic [2:0]  HB_CNT_HI    = 3'h6;
   localparam logic [2:0]  HB_CNT_LO    = 3'h7;

   // ****************************************
   // command and reply codes
   // ****************************************
   localparam logic [7:0]  CMD_ERASE    = 8'h01;
   localparam logic [7:0]  CMD_WRITE    = 8'h02;
   localparam logic [7:0]  CMD_ETW      = 8'h03;
   localparam logic [7:0]  REPLY_BIT    = 8'h80;
   localparam int unsigned FLAG_FAIL    = 0;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [3:0]  REG_CTRL     = 4'h0;
   localparam logic [3:0]  REG_STATUS   = 4'h4;
   localparam logic [3:0]  REG_COUNT    = 4'h8;
   localparam logic        CTRL_EN_RST  = 1'b1;
   localparam int unsigned ST_BUSY      = 0;
   localparam int unsigned ST_ERR       = 1;
   localparam int unsigned ST_CODE_LSB  = 8;

   // ****************************************
   // types
   // ****************************************
   typedef struct packed {
      logic [7:0]  code;
      logic [7:0]  opt;
      logic [15:0] blk;
      logic [15:0] ofs;
      logic [15:0] cnt;
   } fse_hdr_t;

   typedef struct packed {
      logic [7:0]  code;
      logic [7:0]  flags;
      logic [15:0] blk;
      logic [15:0] ofs;
      logic [15:0] cnt;
   } fse_reply_t;

   typedef struct packed {
      logic             req;
      logic             erase;
      logic [BLK_W-1:0] blk;
      logic [OFS_W-1:0] ofs;
      logic [7:0]       data;
   } fse_flash_t;

   typedef enum logic [7:0] {
      S_HDR   = 8'b00000001,
      S_EWAIT = 8'b00000010,
      S_DATA  = 8'b00000100,
      S_PWAIT = 8'b00001000,
      S_FIN   = 8'b00010000,
      S_DRAIN = 8'b00100000,
      S_REPLY = 8'b01000000,
      S_SPARE = 8'b10000000
   } fse_state_t;

endpackage : fse_pkg

// file: rtl/fse_reply_tx.sv
`timescale 1ns/1ps
module fse_reply_tx
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              resetn,
   // reply to send
   input  wire logic              load,
   input  wire fse_pkg::fse_reply_t reply,
   output logic                   busy,
   // byte stream out
   output logic                   out_valid,
   output logic [7:0]             out_data,
   output logic                   out_last,
   input  wire logic              out_ready
);

   typedef struct packed {
      logic        active;
      logic [2:0]  idx;
      logic        last;
      logic [63:0] sh;
   } fse_tx_t;

   fse_tx_t s_r;
   fse_tx_t s_nxt;

   always_comb
   begin
      s_nxt = s_r;
      if (load && !s_r.active)
      begin
         s_nxt.active = 1'b1;
         s_nxt.idx    = 3'h0;
         s_nxt.last   = 1'b0;
         s_nxt.sh     = reply;
      end
      else if (s_r.active && out_ready)
      begin
         // big-endian: high byte of each field leaves first
         s_nxt.sh     = {s_r.sh[55:0], 8'h00};
         s_nxt.idx    = s_r.idx + 3'h1;
         s_nxt.last   = (s_r.idx == 3'h6);
         s_nxt.active = !s_r.last;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign busy      = s_r.active;
   assign out_valid = s_r.active;
   assign out_data  = s_r.sh[63:56];
   assign out_last  = s_r.last;

endmodule : fse_reply_tx

// file: rtl/fse_cmd.sv
// Operation
// - code 01 erases block to all ones
// - byte_count zero erases every block
// - erase works on whole blocks, offset unused
// - unicast erase answered with code 81
// - result_flags bit 0 marks failure
// - reply echoes block_index and byte_offset
// - reply byte_count zero, no payload
// - code 02 programs payload from byte_offset
// - code 03 erases block then programs
// - header fields at bytes 0..7, big-endian
// - broadcast commands get no reply
// - storage is 119 blocks of 512 bytes
// - write replies 82, erase-then-write 83
`timescale 1ns/1ps
module fse_cmd
#(
   parameter int unsigned NUM_BLOCKS  = fse_pkg::NUM_BLOCKS,
   parameter int unsigned BLOCK_BYTES = fse_pkg::BLOCK_BYTES
)
(
   // clock and reset
   input  wire logic                      clk,
   input  wire logic                      resetn,
   // command byte stream
   input  wire logic                      in_valid,
   input  wire logic [7:0]                in_data,
   input  wire logic                      in_last,
   input  wire logic                      in_bcast,
   output logic                           in_ready,
   // reply byte stream
   output logic                           out_valid,
   output logic [7:0]                     out_data,
   output logic                           out_last,
   input  wire logic                      out_ready,
   // flash array port
   output logic                           fl_req,
   output logic                           fl_erase,
   output logic [fse_pkg::BLK_W-1:0]      fl_blk,
   output logic [fse_pkg::OFS_W-1:0]      fl_ofs,
   output logic [7:0]                     fl_data,
   input  wire logic                      fl_done,
   input  wire logic                      fl_error,
   // register port
   input  wire logic [3:0]                reg_addr,
   input  wire logic [31:0]               reg_wdata,
   input  wire logic                      reg_wr,
   input  wire logic                      reg_rd,
   output logic [31:0]                    reg_rdata
);

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      fse_pkg::fse_state_t         st;
      logic [2:0]                  hidx;
      fse_pkg::fse_hdr_t           hdr;
      logic [15:0]                 remain;
      logic [fse_pkg::OFS_W-1:0]   wofs;
      logic [fse_pkg::BLK_W-1:0]   eblk;
      logic                        all;
      logic                        err;
      logic                        seen_last;
      logic                        bcast;
      logic                        skip;
      logic                        in_ready;
      fse_pkg::fse_flash_t         fl;
      logic                        rep_load;
      fse_pkg::fse_reply_t         rep;
      logic                        en;
      logic                        last_err;
      logic [7:0]                  last_code;
      logic [15:0]                 count;
      logic [31:0]                 rdata;
   } fse_cmd_t;

   fse_cmd_t s_r;
   fse_cmd_t s_nxt;
   logic     take;
   logic     tx_busy;

   // ****************************************
   // range checks
   // ****************************************
   function automatic logic blk_ok(input logic [15:0] b);
      blk_ok = ({16'h0, b} < 32'(NUM_BLOCKS));
   endfunction : blk_ok

   function automatic logic span_ok(input logic [15:0] o, input logic [15:0] c);
      logic [16:0] e;
      e = {1'b0, o} + {1'b0, c};
      span_ok = ({15'h0, e} <= 32'(BLOCK_BYTES));
   endfunction : span_ok

   assign take = s_r.in_ready && in_valid;

   // ****************************************
   // command sequencer
   // ****************************************
   always_comb
   begin
      s_nxt          = s_r;
      s_nxt.fl.req   = 1'b0;
      s_nxt.rep_load = 1'b0;
      s_nxt.rdata    = 32'h0;
      case (s_r.st)
         fse_pkg::S_HDR:
         begin
            if (take)
            begin
               case (s_r.hidx)
                  fse_pkg::HB_CODE:
                  begin
                     s_nxt.hdr.code = in_data;
                     s_nxt.bcast    = in_bcast;
                  end
                  fse_pkg::HB_OPT:    s_nxt.hdr.opt      = in_data;
                  fse_pkg::HB_BLK_HI: s_nxt.hdr.blk[15:8] = in_data;
                  fse_pkg::HB_BLK_LO: s_nxt.hdr.blk[7:0]  = in_data;
                  fse_pkg::HB_OFS_HI: s_nxt.hdr.ofs[15:8] = in_data;
                  fse_pkg::HB_OFS_LO: s_nxt.hdr.ofs[7:0]  = in_data;
                  fse_pkg::HB_CNT_HI: s_nxt.hdr.cnt[15:8] = in_data;
                  default:            s_nxt.hdr.cnt[7:0]  = in_data;
               endcase
               s_nxt.hidx = s_r.hidx + 3'h1;
               if (s_r.hidx == fse_pkg::HB_CNT_LO)
               begin
                  s_nxt.hidx      = 3'h0;
                  s_nxt.seen_last = in_last;
                  s_nxt.err       = 1'b0;
                  s_nxt.skip      = 1'b0;
                  s_nxt.all       = 1'b0;
                  s_nxt.remain    = s_nxt.hdr.cnt;
                  s_nxt.wofs      = s_nxt.hdr.ofs[fse_pkg::OFS_W-1:0];
                  s_nxt.eblk      = s_nxt.hdr.blk[fse_pkg::BLK_W-1:0];
                  s_nxt.st        = fse_pkg::S_FIN;
                  case (s_nxt.hdr.code)
                     fse_pkg::CMD_ERASE:
                     begin
                        // offset is never looked at: whole blocks only
                        if (s_nxt.hdr.cnt == 16'h0)
                        begin
                           s_nxt.all  = 1'b1;
                           s_nxt.eblk = '0;
                           s_nxt.st   = fse_pkg::S_EWAIT;
                        end
                        else if (blk_ok(s_nxt.hdr.blk))
                           s_nxt.st = fse_pkg::S_EWAIT;
                        else
                           s_nxt.err = 1'b1;
                     end
                     fse_pkg::CMD_WRITE, fse_pkg::CMD_ETW:
                     begin
                        if (!blk_ok(s_nxt.hdr.blk) || !span_ok(s_nxt.hdr.ofs, s_nxt.hdr.cnt))
                           s_nxt.err = 1'b1;
                        else if (s_nxt.hdr.code == fse_pkg::CMD_ETW)
                           s_nxt.st = fse_pkg::S_EWAIT;
                        else if (s_nxt.hdr.cnt != 16'h0)
                        begin
                           // short frame: count promised more than came
                           if (in_last)
                              s_nxt.err = 1'b1;
                           else
                              s_nxt.st = fse_pkg::S_DATA;
                        end
                     end
                     default: s_nxt.skip = 1'b1;
                  endcase
                  if (s_nxt.st == fse_pkg::S_EWAIT)
                  begin
                     s_nxt.fl.req   = 1'b1;
                     s_nxt.fl.erase = 1'b1;
                     s_nxt.fl.blk   = s_nxt.eblk;
                  end
               end
               else if (in_last)
                  s_nxt.hidx = 3'h0; // runt frame dropped silently
            end
         end
         fse_pkg::S_EWAIT:
         begin
            if (fl_done)
            begin
               s_nxt.st = fse_pkg::S_FIN;
               if (fl_error)
                  s_nxt.err = 1'b1;
               else if (s_r.all && ({25'h0, s_r.eblk} != 32'(NUM_BLOCKS - 1)))
               begin
                  s_nxt.eblk     = s_r.eblk + 1'b1;
                  s_nxt.fl.req   = 1'b1;
                  s_nxt.fl.erase = 1'b1;
                  s_nxt.fl.blk   = s_nxt.eblk;
                  s_nxt.st       = fse_pkg::S_EWAIT;
               end
               else if (s_r.hdr.code == fse_pkg::CMD_ETW && s_r.remain != 16'h0)
               begin
                  if (s_r.seen_last)
                     s_nxt.err = 1'b1;
                  else
                     s_nxt.st = fse_pkg::S_DATA;
               end
            end
         end
         fse_pkg::S_DATA:
         begin
            if (take)
            begin
               s_nxt.fl.req    = 1'b1;
               s_nxt.fl.erase  = 1'b0;
               s_nxt.fl.blk    = s_r.hdr.blk[fse_pkg::BLK_W-1:0];
               s_nxt.fl.ofs    = s_r.wofs;
               s_nxt.fl.data   = in_data;
               s_nxt.wofs      = s_r.wofs + 1'b1;
               s_nxt.remain    = s_r.remain - 16'h1;
               s_nxt.seen_last = in_last;
               s_nxt.st        = fse_pkg::S_PWAIT;
            end
         end
         fse_pkg::S_PWAIT:
         begin
            if (fl_done)
            begin
               s_nxt.st = fse_pkg::S_FIN;
               if (fl_error)
                  s_nxt.err = 1'b1;
               else if (s_r.remain != 16'h0)
               begin
                  if (s_r.seen_last)
                     s_nxt.err = 1'b1;
                  else
                     s_nxt.st = fse_pkg::S_DATA;
               end
            end
         end
         fse_pkg::S_FIN:
            s_nxt.st = s_r.seen_last ? fse_pkg::S_REPLY : fse_pkg::S_DRAIN;
         fse_pkg::S_DRAIN:
         begin
            // surplus bytes are swallowed so the next frame starts clean
            if (take && in_last)
            begin
               s_nxt.seen_last = 1'b1;
               s_nxt.st        = fse_pkg::S_REPLY;
            end
         end
         fse_pkg::S_REPLY:
         begin
            if (!tx_busy)
            begin
               s_nxt.rep_load  = !(s_r.bcast || s_r.skip);
               s_nxt.rep.code  = s_r.hdr.code | fse_pkg::REPLY_BIT;
               s_nxt.rep.flags = 8'h0;
               s_nxt.rep.flags[fse_pkg::FLAG_FAIL] = s_r.err;
               s_nxt.rep.blk   = s_r.hdr.blk;
               s_nxt.rep.ofs   = s_r.hdr.ofs;
               s_nxt.rep.cnt   = 16'h0;
               if (!s_r.skip)
               begin
                  s_nxt.last_err  = s_r.err;
                  s_nxt.last_code = s_r.hdr.code;
                  s_nxt.count     = s_r.count + 16'h1;
               end
               s_nxt.st = fse_pkg::S_HDR;
            end
         end
         default: s_nxt.st = fse_pkg::S_HDR;
      endcase

      // ready is registered, so it follows the state being entered
      s_nxt.in_ready = (s_nxt.st == fse_pkg::S_DATA) || (s_nxt.st == fse_pkg::S_DRAIN) ||
                       (s_nxt.st == fse_pkg::S_HDR && s_nxt.en);

      // ****************************************
      // register port
      // ****************************************
      if (reg_wr && reg_addr == fse_pkg::REG_CTRL)
         s_nxt.en = reg_wdata[0];
      if (reg_rd)
      begin
         case (reg_addr)
            fse_pkg::REG_CTRL:   s_nxt.rdata[0] = s_r.en;
            fse_pkg::REG_STATUS:
            begin
               s_nxt.rdata[fse_pkg::ST_BUSY] = (s_r.st != fse_pkg::S_HDR) || (s_r.hidx != 3'h0);
               s_nxt.rdata[fse_pkg::ST_ERR]  = s_r.last_err;
               s_nxt.rdata[fse_pkg::ST_CODE_LSB +: 8] = s_r.last_code;
            end
            fse_pkg::REG_COUNT:  s_nxt.rdata[15:0] = s_r.count;
            default:             s_nxt.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s_r          <= '0;
         s_r.st       <= fse_pkg::S_HDR;
         s_r.en       <= fse_pkg::CTRL_EN_RST;
         s_r.in_ready <= fse_pkg::CTRL_EN_RST;
      end
      else
         s_r <= s_nxt;
   end

   // ****************************************
   // reply serializer and outputs
   // ****************************************
   fse_reply_tx u_tx
   (
      .clk       (clk),
      .resetn    (resetn),
      .load      (s_r.rep_load),
      .reply     (s_r.rep),
      .busy      (tx_busy),
      .out_valid (out_valid),
      .out_data  (out_data),
      .out_last  (out_last),
      .out_ready (out_ready)
   );

   assign in_ready  = s_r.in_ready;
   assign fl_req    = s_r.fl.req;
   assign fl_erase  = s_r.fl.erase;
   assign fl_blk    = s_r.fl.blk;
   assign fl_ofs    = s_r.fl.ofs;
   assign fl_data   = s_r.fl.data;
   assign reg_rdata = s_r.rdata;

endmodule : fse_cmd

// file: verification/fse_cmd_chk.sv
`timescale 1ns/1ps
module fse_cmd_chk
#(
   parameter int unsigned NUM_BLOCKS  = fse_pkg::NUM_BLOCKS,
   parameter int unsigned BLOCK_BYTES = fse_pkg::BLOCK_BYTES
)
(
   // clock and reset
   input wire logic       clk,
   input wire logic       resetn,
   // command stream
   input wire logic       in_valid,
   input wire logic [7:0] in_data,
   input wire logic       in_last,
   input wire logic       in_bcast,
   input wire logic       in_ready,
   // reply stream
   input wire logic       out_valid,
   input wire logic [7:0] out_data,
   input wire logic       out_last,
   input wire logic       out_ready,
   // flash port
   input wire logic       fl_req,
   input wire logic       fl_erase,
   input wire logic [6:0] fl_blk,
   input wire logic [7:0] fl_data
);
   // ****************************************
   // frame trackers
   // ****************************************
   typedef struct packed {
      logic [2:0]  ocnt;
      logic [3:0]  icnt;
      logic        bc;
      logic [31:0] echo;
   } fse_chk_st_t;

   fse_chk_st_t st_r;
   fse_chk_st_t st_nxt;

   always_comb
   begin
      st_nxt = st_r;
      if (out_valid && out_ready)
         st_nxt.ocnt = st_r.ocnt + 3'h1;
      if (in_valid && in_ready)
      begin
         if (st_r.icnt == 4'h0)
            st_nxt.bc = in_bcast;
         if (st_r.icnt >= 4'h2 && st_r.icnt <= 4'h5)
            st_nxt.echo = {st_r.echo[23:0], in_data};
         st_nxt.icnt = in_last ? 4'h0 : (st_r.icnt == 4'h8 ? 4'h8 : st_r.icnt + 4'h1);
      end
   end

   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
         st_r <= '0;
      else
         st_r <= st_nxt;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   property p_code; out_valid && st_r.ocnt == 3'h0 |-> out_data inside {8'h81, 8'h82, 8'h83}; endproperty
   a_code: assert property (p_code) else $error("bad reply code");
   property p_flags; out_valid && st_r.ocnt == 3'h1 |-> out_data[7:1] == 7'h00; endproperty
   a_flags: assert property (p_flags) else $error("reserved flag set");
   property p_echo; out_valid && st_r.ocnt inside {[2:5]} |-> out_data == 8'(st_r.echo >> (8 * (5 - st_r.ocnt)));
   endproperty
   a_echo: assert property (p_echo) else $error("echo mismatch");
   property p_zero; out_valid && st_r.ocnt[2:1] == 2'b11 |-> out_data == 8'h00; endproperty
   a_zero: assert property (p_zero) else $error("count not zero");
   property p_last; out_valid |-> out_last == (st_r.ocnt == 3'h7); endproperty
   a_last: assert property (p_last) else $error("reply length wrong");
   property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_last); endproperty
   a_hold: assert property (p_hold) else $error("reply byte dropped");
   property p_bcast; out_valid |-> !st_r.bc; endproperty
   a_bcast: assert property (p_bcast) else $error("broadcast answered");
   property p_blk; fl_req |-> fl_blk < NUM_BLOCKS; endproperty
   a_blk: assert property (p_blk) else $error("block out of range");
   property p_prog; fl_req && !fl_erase |-> $past(in_valid && in_ready) && fl_data == $past(in_data); endproperty
   a_prog: assert property (p_prog) else $error("program data wrong");

   c_erase: cover property (fl_req && fl_erase);
   c_prog: cover property (fl_req && !fl_erase);
   c_reply: cover property (out_valid && out_ready && out_last);
endmodule : fse_cmd_chk

bind fse_cmd fse_cmd_chk #(.NUM_BLOCKS(NUM_BLOCKS), .BLOCK_BYTES(BLOCK_BYTES)) i_chk
   (.clk(clk), .resetn(resetn), .in_valid(in_valid), .in_data(in_data), .in_last(in_last), .in_bcast(in_bcast),
    .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data), .out_last(out_last), .out_ready(out_ready),
    .fl_req(fl_req), .fl_erase(fl_erase), .fl_blk(fl_blk), .fl_data(fl_data));

// file: verification/fse_flash_model.sv
`timescale 1ns/1ps
module fse_flash_model
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // flash port
   input  wire logic       fl_req,
   input  wire logic       fl_erase,
   input  wire logic [6:0] fl_blk,
   input  wire logic [8:0] fl_ofs,
   input  wire logic [7:0] fl_data,
   output logic            fl_done,
   output logic            fl_error,
   // test controls
   input  wire logic [3:0] lat,
   input  wire logic       inject
);
   // ****************************************
   // array behaviour
   // ****************************************
   logic [7:0] mem [fse_pkg::NUM_BLOCKS * fse_pkg::BLOCK_BYTES];
   logic       busy;
   logic [3:0] wait_n;
   logic       er;
   int         base;
   logic [7:0] dat;

   initial
   begin
      foreach (mem[i])
         mem[i] = 8'h00;
   end

   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         busy <= 1'b0;
         fl_done <= 1'b0;
         fl_error <= 1'b0;
      end
      else
      begin
         fl_done <= 1'b0;
         if (fl_req)
         begin
            busy <= 1'b1;
            wait_n <= lat;
            er <= fl_erase;
            base <= fl_blk * fse_pkg::BLOCK_BYTES + (fl_erase ? 0 : fl_ofs);
            dat <= fl_data;
         end
         else if (busy && wait_n != 4'h0)
            wait_n <= wait_n - 4'h1;
         else if (busy)
         begin
            busy <= 1'b0;
            fl_done <= 1'b1;
            fl_error <= inject;
            if (!inject && er)
               for (int i = 0; i < fse_pkg::BLOCK_BYTES; i++)
                  mem[base + i] <= 8'hff;
            else if (!inject)
               mem[base] <= mem[base] & dat;
         end
      end
   end
endmodule : fse_flash_model

// file: verification/tb.sv
`timescale 1ns/1ps
module tb;
   // ****************************************
   // bench
   // ****************************************
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        in_valid = 1'b0;
   logic [7:0]  in_data = 8'h00;
   logic        in_last = 1'b0;
   logic        in_bcast = 1'b0;
   logic        in_ready;
   logic        out_valid;
   logic [7:0]  out_data;
   logic        out_last;
   logic        out_ready = 1'b0;
   logic        fl_req;
   logic        fl_erase;
   logic [6:0]  fl_blk;
   logic [8:0]  fl_ofs;
   logic [7:0]  fl_data;
   logic        fl_done;
   logic        fl_error;
   logic [3:0]  reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [3:0]  lat = 4'h0;
   logic        inject = 1'b0;
   logic [7:0]  pay [16];
   logic [31:0] d;
   logic        seen;
   logic [15:0] b;
   logic [15:0] o;
   logic [15:0] c;
   int          n_errors = 0;
   int          n_compared = 0;
   int          seed = 58;

   always #12.5 clk = ~clk;

   fse_cmd i_dut (.clk(clk), .resetn(resetn), .in_valid(in_valid), .in_data(in_data), .in_last(in_last),
      .in_bcast(in_bcast), .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
      .out_ready(out_ready), .fl_req(fl_req), .fl_erase(fl_erase), .fl_blk(fl_blk), .fl_ofs(fl_ofs),
      .fl_data(fl_data), .fl_done(fl_done), .fl_error(fl_error), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   fse_flash_model i_fl (.clk(clk), .resetn(resetn), .fl_req(fl_req), .fl_erase(fl_erase), .fl_blk(fl_blk),
      .fl_ofs(fl_ofs), .fl_data(fl_data), .fl_done(fl_done), .fl_error(fl_error), .lat(lat), .inject(inject));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic final_report;
      $display("errors=%0d compared=%0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : final_report

   task automatic send(input logic [7:0] v, input logic last);
      int n;
      in_valid <= 1'b1;
      in_data <= v;
      in_last <= last;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (in_ready !== 1'b1 && n < 4000);
      if (in_ready !== 1'b1) n_errors++;
   endtask : send

   task automatic frame(input logic [7:0] code, input logic [15:0] blk, ofs, cnt, input int np, input logic bc);
      logic [63:0] h;
      h = {code, 8'h00, blk, ofs, cnt};
      in_bcast <= bc;
      for (int i = 0; i < 8 + np; i++)
         send(i < 8 ? h[63 - 8 * i -: 8] : pay[i - 8], i == 7 + np);
      in_valid <= 1'b0;
      in_last <= 1'b0;
   endtask : frame

   task automatic xfer(input logic [7:0] code, input logic [15:0] blk, ofs, cnt, input int np, input logic fail);
      logic [63:0] e;
      int n;
      frame(code, blk, ofs, cnt, np, 1'b0);
      e = {code | 8'h80, 7'h00, fail, blk, ofs, 16'h0000};
      n = 0;
      for (int i = 0; i < 8; i++)
      begin
         do
         begin
            // random stalls on the reply sink
            out_ready <= 1'($random(seed));
            @(posedge clk);
            n++;
         end
         while (!(out_valid === 1'b1 && out_ready === 1'b1) && n < 4000);
         check({out_last, out_data}, {i == 7, e[63 - 8 * i -: 8]});
      end
      out_ready <= 1'b0;
   endtask : xfer

   task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      v = reg_rdata;
   endtask : reg_read

   initial
   begin
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      reg_read(fse_pkg::REG_CTRL, d);
      check(d, 32'h0000_0001);
      reg_write(fse_pkg::REG_COUNT, 32'h0000_ffff);
      reg_read(fse_pkg::REG_COUNT, d);
      check(d, 32'h0000_0000);
      reg_read(4'hc, d);
      check(d, 32'h0000_0000);
      xfer(fse_pkg::CMD_ERASE, 16'h002a, 16'h0000, 16'h0200, 0, 1'b0);
      for (int j = 511; j <= 1024; j++)
         check(i_fl.mem[41 * 512 + j], (j == 511 || j == 1024) ? 8'h00 : 8'hff);
      for (int k = 0; k < 6; k++)
      begin
         b = 16'(43 + $unsigned($random(seed)) % 76); // block 42 stays clean for the plain write
         o = 16'($unsigned($random(seed)) % 496);
         c = 16'(1 + $unsigned($random(seed)) % 16);
         // first pass hits the last block and the last byte
         if (k == 0)
         begin
            b = 16'h0076;
            o = 16'h01f0;
            c = 16'h0010;
         end
         lat <= 4'($random(seed));
         foreach (pay[i])
            pay[i] = 8'($random(seed));
         xfer(fse_pkg::CMD_ETW, b, o, c, int'(c), 1'b0);
         for (int j = 0; j < 512; j++)
            check(i_fl.mem[b * 512 + j], (j >= o && j < o + c) ? pay[j - o] : 8'hff);
         reg_read(fse_pkg::REG_STATUS, d);
         check(d[15:0], 16'h0300);
      end
      xfer(fse_pkg::CMD_WRITE, 16'h002a, 16'h01f4, 16'h000c, 12, 1'b0);
      for (int j = 499; j < 512; j++)
         check(i_fl.mem[42 * 512 + j], j == 499 ? 8'hff : pay[j - 500]);
      xfer(fse_pkg::CMD_WRITE, 16'h0077, 16'h0000, 16'h0001, 1, 1'b1);
      xfer(fse_pkg::CMD_WRITE, 16'h002a, 16'h01f2, 16'h000f, 15, 1'b1);
      check(i_fl.mem[42 * 512 + 498], 8'hff);
      inject <= 1'b1;
      xfer(fse_pkg::CMD_WRITE, 16'h002a, 16'h0000, 16'h0001, 1, 1'b1);
      inject <= 1'b0;
      reg_read(fse_pkg::REG_STATUS, d);
      check(d[1], 1'b1);
      frame(fse_pkg::CMD_ERASE, 16'h0005, 16'h0000, 16'h0200, 0, 1'b1);
      seen = 1'b0;
      repeat (300)
      begin
         out_ready <= 1'b1;
         @(posedge clk);
         seen = seen | (out_valid === 1'b1);
      end
      check(seen, 1'b0);
      check(i_fl.mem[5 * 512 + 7], 8'hff);
      lat <= 4'h0;
      xfer(fse_pkg::CMD_ERASE, 16'h004d, 16'h0000, 16'h0000, 0, 1'b0);
      for (int j = 0; j < 119; j++)
         check({i_fl.mem[j * 512], i_fl.mem[j * 512 + 511]}, 16'hffff);
      reg_read(fse_pkg::REG_COUNT, d);
      check(d, 32'h0000_000d);
      reg_write(fse_pkg::REG_CTRL, 32'h0000_0000);
      repeat (2) @(posedge clk);
      check(in_ready, 1'b0);
      reg_write(fse_pkg::REG_CTRL, 32'h0000_0001);
      repeat (2) @(posedge clk);
      check(in_ready, 1'b1);
      final_report;
   end

   initial
   begin
      #2_000_000;
      n_errors++;
      final_report;
   end
endmodule : tb
